//--- dv/hcp_host_model.sv
// Host processor model driving the parallel port
`timescale 1ns/1ps
`default_nettype none
module hcp_host_model (
  input  wire logic       clk_sys,
  input  wire logic       style,
  input  wire logic       mux,
  input  wire logic       ack_pin,
  input  wire logic       ack_oe,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  output logic            sel_n,
  output logic            strobe_n,
  output logic            dir,
  output logic      [7:1] addr_hi,
  output logic            addr0_ale,
  output logic      [7:0] data_in
);
  logic [7:0] drv = 8'h00;
  // During a read the released bus shows inverse of the address, never a stale match
  assign data_in = data_oe ? data_out : drv;
  initial begin
    sel_n = 1'b1;
    strobe_n = 1'b1;
    dir = 1'b1;
    addr_hi = 7'h00;
    addr0_ale = 1'b0;
  end
  task automatic access(input logic en, input logic rd, input logic [7:0] a,
                        input logic [7:0] wd, output logic [7:0] rdv, output logic ok);
    @(negedge clk_sys);
    if (mux) begin
      addr0_ale = 1'b1;
      drv = a;
      @(negedge clk_sys);
      addr0_ale = 1'b0;
      @(negedge clk_sys);
    end
    addr_hi = a[7:1];
    if (!mux) addr0_ale = a[0];
    drv = rd ? ~a : wd;
    sel_n = ~en;
    if (style) begin
      dir = rd;
      strobe_n = 1'b0;
    end else if (rd) dir = 1'b0;
    else strobe_n = 1'b0;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(negedge clk_sys);
      ok = ack_oe === 1'b1 && ack_pin === ~style;
      rdv = data_in;
    end
    sel_n = 1'b1;
    strobe_n = 1'b1;
    dir = 1'b1;
  endtask : access
endmodule : hcp_host_model
`default_nettype wire

//--- dv/host_cpu_port_pins_test.sv
// Self-checking bench for the host port
`timescale 1ns/1ps
`default_nettype none
module host_cpu_port_pins_test;
  logic clk_sys = 0, rst = 1, style_strap = 0, mux_strap = 0, irq_req = 0;
  logic sel_n, strobe_n, dir, addr0_ale, data_oe, irq_pin, ack_pin, ack_oe, reg_wr, reg_rd, ok;
  logic [7:1] addr_hi;
  logic [7:0] data_in, data_out, reg_addr, reg_wdata, rdv, wr_a, wr_d;
  int n_fail = 0, tests_run = 0, n_wr = 0;
  wire [7:0] reg_rdata = ~reg_addr ^ 8'h5a;
  initial forever #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (reg_wr === 1'b1) begin
    wr_a <= reg_addr;
    wr_d <= reg_wdata;
    n_wr <= n_wr + 1;
  end
  hcp_port u_hcp_port (.clk_sys(clk_sys), .rst(rst), .style_strap(style_strap),
    .mux_strap(mux_strap), .addr_hi(addr_hi), .addr0_ale(addr0_ale), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .sel_n(sel_n), .write_or_data_strobe_n(strobe_n),
    .read_or_dir(dir), .irq_pin(irq_pin), .ack_pin(ack_pin), .ack_oe(ack_oe),
    .irq_req(irq_req), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  hcp_host_model u_hcp_host_model (.clk_sys(clk_sys), .style(style_strap), .mux(mux_strap),
    .ack_pin(ack_pin), .ack_oe(ack_oe), .data_out(data_out), .data_oe(data_oe),
    .sel_n(sel_n), .strobe_n(strobe_n), .dir(dir), .addr_hi(addr_hi),
    .addr0_ale(addr0_ale), .data_in(data_in));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic run_mode(input logic s, input logic m);
    int w0;
    @(negedge clk_sys);
    rst = 1'b1;
    style_strap = s;
    mux_strap = m;
    repeat (8) @(negedge clk_sys);
    check(data_oe, 1'b0, "data bus driven in reset");
    check(ack_oe, 1'b0, "ack driven in reset");
    check(irq_pin, s, "irq idle level");
    rst = 1'b0;
    w0 = n_wr;
    u_hcp_host_model.access(1'b0, 1'b0, 8'h11, 8'h22, rdv, ok);
    check(ok, 1'b0, "ack while deselected");
    check(n_wr - w0, 0, "write while deselected");
    u_hcp_host_model.access(1'b1, 1'b0, 8'h3b, 8'ha5, rdv, ok);
    check(ok, 1'b1, "write not acknowledged");
    check(wr_a, 8'h3b, "write address");
    check(wr_d, 8'ha5, "write data");
    u_hcp_host_model.access(1'b1, 1'b1, 8'hc4, 8'h00, rdv, ok);
    check(rdv, ~8'hc4 ^ 8'h5a, "read data");
    @(negedge clk_sys);
    check(data_oe, 1'b0, "bus held after read");
    irq_req = 1'b1;
    repeat (2) @(negedge clk_sys);
    check(irq_pin, !s, "irq active level");
    irq_req = 1'b0;
    $display("test done style %0d mux %0d", s, m);
  endtask : run_mode
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end
  initial begin
    for (int i = 0; i < 4; i++) run_mode(i[0], i[1]);
    wrap_up();
  end
endmodule : host_cpu_port_pins_test
`default_nettype wire

//--- src/hcp_params.svh
// Constants for the host CPU port pin logic
`ifndef HCP_PARAMS_SVH
`define HCP_PARAMS_SVH
`define HCP_ADDR_W        8
`define HCP_DATA_W        8
`define HCP_STYLE_SEPARATE 1'b0
`define HCP_STYLE_DSTROBE  1'b1
`define HCP_DATA_RST      8'h00
`define HCP_ACK_LAT_NS    16
`define HCP_CLK_NS        8
`define HCP_ACK_CYC       ((`HCP_ACK_LAT_NS + `HCP_CLK_NS - 1) / `HCP_CLK_NS)
`endif

//--- src/hcp_pkg.sv
// Types for the host CPU port pin logic
package hcp_pkg;
  typedef enum logic [3:0] {
    HCP_IDLE = 4'b0001,
    HCP_WAIT = 4'b0010,
    HCP_DONE = 4'b0100,
    HCP_HOLD = 4'b1000
  } hcp_state_t;
endpackage : hcp_pkg

//--- src/hcp_port.sv
// Parallel host CPU port: strobe decode, data bus drive, acknowledge, interrupt
// Behaviour
// R1: Strap low separate strobes, high data strobe
// R2: Mux strap high selects multiplexed address/data
// R3: Lowest address pin is bit 0 or latch
// R4: Host holds upper seven address bits stable
// R5: Eight-bit data bus, released after reset
// R6: Strobes ignored while chip select high
// R7: Shared strobe: write enable or data strobe
// R8: Direction pin: read enable or read/write
// R9: Interrupt polarity follows bus style, idle reset
// R10: Acknowledge marks completion, polarity by style
// R11: Drive data only while selected and reading
`include "hcp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module hcp_port
  import hcp_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       style_strap,
  input  wire logic       mux_strap,
  input  wire logic [7:1] addr_hi,
  input  wire logic       addr0_ale,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  input  wire logic       sel_n,
  input  wire logic       write_or_data_strobe_n,
  input  wire logic       read_or_dir,
  output logic            irq_pin,
  output logic            ack_pin,
  output logic            ack_oe,
  input  wire logic       irq_req,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);

  logic       style_r;
  logic       mux_r;
  logic [7:0] mux_addr_r;
  logic       ale_q_r;
  hcp_state_t state_r;
  hcp_state_t state_nxt;
  logic [1:0] cnt_r;
  logic       is_rd_r;
  logic [7:0] rdata_r;
  logic       irq_r;

  // Decoded host request as (active, read)
  function automatic logic [1:0] decode(input logic sty, input logic ws_n, input logic rd);
    logic [1:0] res;
    res = 2'b00;
    if (sty == `HCP_STYLE_SEPARATE) begin
      if (!ws_n) res = 2'b10; // [R7]
      else if (!rd) res = 2'b11; // [R8]
    end else begin
      if (!ws_n) res = {1'b1, rd}; // [R7] [R8]
    end
    return res;
  endfunction : decode

  logic [1:0] req;
  logic       active;
  logic       rd_req;
  assign req    = decode(style_r, write_or_data_strobe_n, read_or_dir);
  assign active = !sel_n && req[1]; // [R6]
  assign rd_req = req[0];

  // Straps caught on every clock while reset is high, held after release
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      style_r <= style_strap; // [R1]
      mux_r   <= mux_strap; // [R2]
    end
  end

  // Address latch on ale falling edge in multiplexed mode
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ale_q_r    <= 1'b0;
      mux_addr_r <= 8'h00;
    end else begin
      ale_q_r <= addr0_ale;
      if (ale_q_r && !addr0_ale) mux_addr_r <= data_in; // [R3]
    end
  end

  always_comb begin
    if (mux_r) reg_addr = mux_addr_r; // [R2] [R3]
    else reg_addr = {addr_hi, addr0_ale}; // [R3] [R4]
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      HCP_IDLE: if (active) state_nxt = HCP_WAIT;
      HCP_WAIT: if (!active) state_nxt = HCP_IDLE;
                else if (cnt_r == 2'(`HCP_ACK_CYC - 1)) state_nxt = HCP_DONE;
      HCP_DONE: state_nxt = HCP_HOLD;
      HCP_HOLD: if (!active) state_nxt = HCP_IDLE;
      default:  state_nxt = HCP_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) state_r <= HCP_IDLE;
    else state_r <= state_nxt;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) cnt_r <= 2'd0;
    else if (state_r == HCP_WAIT) cnt_r <= cnt_r + 2'd1;
    else cnt_r <= 2'd0;
  end

  // At most one access pulse per strobe, at the end of the wait
  assign reg_wr    = (state_r == HCP_DONE) && !is_rd_r;
  assign reg_rd    = (state_r == HCP_DONE) && is_rd_r;
  assign reg_wdata = data_in;

  always_ff @(posedge clk_sys) begin
    if (rst) is_rd_r <= 1'b0;
    else if (state_r == HCP_IDLE && active) is_rd_r <= rd_req;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) rdata_r <= `HCP_DATA_RST;
    else if (reg_rd) rdata_r <= reg_rdata;
  end

  assign data_out = rdata_r;
  // Released whenever strobes drop so no bus fight at turnaround
  assign data_oe  = active && is_rd_r && (state_r == HCP_HOLD); // [R5] [R11]

  // Ack driven only during a selected access; high-z otherwise
  assign ack_oe  = active && (state_r != HCP_IDLE); // [R10]
  assign ack_pin = (state_r == HCP_HOLD) ^ style_r; // [R10]

  always_ff @(posedge clk_sys) begin
    if (rst) irq_r <= 1'b0;
    else irq_r <= irq_req;
  end

  assign irq_pin = irq_r ^ style_r; // [R9]

  // Assertions
  a_sel_blocks: assert property (@(posedge clk_sys) disable iff (rst)
    sel_n |-> !data_oe && !ack_oe) else $error("Port active while deselected"); // [R6]
  a_data_read: assert property (@(posedge clk_sys) disable iff (rst)
    data_oe |-> !sel_n && is_rd_r) else $error("Data driven outside read"); // [R11]
  a_data_reset: assert property (@(posedge clk_sys)
    $fell(rst) |-> !data_oe) else $error("Data bus driven after reset"); // [R5]
  a_irq_idle: assert property (@(posedge clk_sys) disable iff (rst)
    !irq_r |-> irq_pin == style_r) else $error("Interrupt idle level wrong"); // [R9]
  a_irq_follow: assert property (@(posedge clk_sys) disable iff (rst)
    irq_req ##1 !rst |-> irq_pin == !style_r) else $error("Interrupt not asserted"); // [R9]
  a_ack_level: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == HCP_HOLD |-> ack_pin == !style_r) else $error("Ack level wrong"); // [R10]
  a_ack_bound: assert property (@(posedge clk_sys) disable iff (rst)
    (state_r == HCP_IDLE && active) ##1 active[*3] |=> state_r == HCP_HOLD)
    else $error("Ack late"); // [R10]
  a_wr_decode: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr |-> $past(active, 1) && !is_rd_r) else $error("Write without strobe"); // [R7]
  a_mux_addr: assert property (@(posedge clk_sys) disable iff (rst)
    !mux_r |-> reg_addr[0] == addr0_ale) else $error("Address bit 0 wrong"); // [R3]
  a_dir_sep: assert property (@(posedge clk_sys) disable iff (rst)
    (state_r == HCP_IDLE && active && !style_r && write_or_data_strobe_n) |=> is_rd_r)
    else $error("Read enable not decoded"); // [R8]

  // Data strobe style: direction taken from the pin at the take edge
  a_ds_dir: assert property (@(posedge clk_sys) disable iff (rst)
    (state_r == HCP_IDLE && active && style_r) |=> is_rd_r == $past(read_or_dir))
    else $error("Direction not captured"); // [R8]

  a_rd_decode: assert property (@(posedge clk_sys) disable iff (rst)
    reg_rd |-> $past(active, 1) && is_rd_r) else $error("Read without strobe"); // [R8]

  // At most one register access per strobe
  a_rd_single: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_rd || reg_wr) |=> !reg_rd && !reg_wr) else $error("Access repeated"); // [R10]

  // Strobe dropped inside the wait: no access at all
  a_wait_abort: assert property (@(posedge clk_sys) disable iff (rst)
    (state_r == HCP_WAIT && !active) |=> state_r == HCP_IDLE && !reg_wr && !reg_rd)
    else $error("Aborted access ran"); // [R6]

  a_ack_release: assert property (@(posedge clk_sys) disable iff (rst)
    !active |-> !ack_oe && !data_oe) else $error("Port held after strobe"); // [R10]

  a_ack_wait_lvl: assert property (@(posedge clk_sys) disable iff (rst)
    (ack_oe && state_r != HCP_HOLD) |-> ack_pin == style_r)
    else $error("Ack active too early"); // [R10]

  a_ack_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (state_r == HCP_HOLD && active) |-> ack_oe && ack_pin == !style_r)
    else $error("Ack not driven in hold"); // [R10]

  // Read data register loads on the access pulse
  a_rd_data: assert property (@(posedge clk_sys) disable iff (rst)
    reg_rd |=> data_out == $past(reg_rdata)) else $error("Read data not captured"); // [R11]

  a_mux_latch: assert property (@(posedge clk_sys) disable iff (rst)
    (mux_r && ale_q_r && !addr0_ale) |=> reg_addr == $past(data_in))
    else $error("Muxed address not latched"); // [R3]

  a_ack_reset: assert property (@(posedge clk_sys)
    $fell(rst) |-> !ack_oe) else $error("Ack driven after reset"); // [R10]

  a_irq_reset: assert property (@(posedge clk_sys)
    $fell(rst) |-> irq_pin == style_r) else $error("Interrupt active after reset"); // [R9]

  c_read: cover property (@(posedge clk_sys) disable iff (rst) reg_rd ##1 data_oe);
  c_write: cover property (@(posedge clk_sys) disable iff (rst) reg_wr);
  c_abort: cover property (@(posedge clk_sys) disable iff (rst)
    state_r == HCP_WAIT ##1 state_r == HCP_IDLE);
  c_latch: cover property (@(posedge clk_sys) disable iff (rst) mux_r && $fell(addr0_ale));
  c_ds_read: cover property (@(posedge clk_sys) disable iff (rst) style_r && reg_rd);

endmodule : hcp_port
`default_nettype wire
